// *** hcr_clock_out.sv ***
// Clock output generator: toggles the output pin on a reference rate
// that is thinned to 1, 3/4 or 1/2. Assumes the crystal rate is clock_in.
`timescale 1ns/1ps
`default_nettype none
module hcr_clock_out
  import hcr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire hcr_divide_t divide_in,
  input wire hcr_drive_t drive_in,
  input wire logic stopped_in,
  output logic clock_out,
  output logic enable_out
);

  logic [1:0] phase_reg;
  logic tick;
  logic running;

  ////////////////////////////////////////////////////////////////////////////
  // Rate selection
  assign running = (divide_in != HCR_DIV_OFF) && (drive_in != HCR_DRIVE_OFF) && !stopped_in;

  always_comb begin
    unique case (divide_in)
      HCR_DIV_ONE: tick = 1'b1;
      HCR_DIV_THREE_QUARTER: tick = (phase_reg != 2'h3); // Swallows one edge in four
      HCR_DIV_HALF: tick = phase_reg[0];
      HCR_DIV_OFF: tick = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output level; held high while disabled, as the pull-up would
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clock_out <= 1'b1;
    end else if (!running) begin
      clock_out <= 1'b1;
    end else if (tick) begin
      clock_out <= !clock_out;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enable_out <= 1'b0;
    end else begin
      enable_out <= running;
    end
  end

  a_off_held_high: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !running |=> clock_out)
    else $error("clock output not high while disabled");

endmodule : hcr_clock_out
`default_nettype wire

// *** hcr_host_model.sv ***
// Host bus controller model driving the card pins of the register bank.
// Assumes hcr_pkg is compiled first; pins change only at falling edges.
`timescale 1ns/1ps
`default_nettype none
module hcr_host_model
  import hcr_pkg::*;
(
  input wire logic clock_in,
  input wire logic [7:0] data_in,
  input wire logic oe_in,
  input wire logic cs_n_in,
  output var hcr_pins_t pins_out
);
  initial pins_out = {4'hF, 26'h0000000, 8'h5A};
  ////////////////////////////////////////////////////////////////////////////
  task automatic go(input int n);
    repeat (n) @(negedge clock_in);
  endtask : go
  // Pins settle three cycles ahead of the strobe to cover the synchroniser
  task automatic wr(input logic [25:0] a, input logic [7:0] d);
    go(1);
    pins_out = {4'b0011, a, d};
    go(3);
    pins_out.we_n = 1'b0;
    go(8);
    pins_out.we_n = 1'b1;
    go(3);
    pins_out = {4'b1111, a, ~d}; // Released lane: no stale data
  endtask : wr
  task automatic rd(input logic [25:0] a, output logic [7:0] d, output logic oe);
    go(1);
    pins_out = {4'b0001, a, ~pins_out.data};
    go(6);
    d = data_in;
    oe = oe_in;
    go(1);
    pins_out.oe_n = 1'b1;
    go(3);
    pins_out = {4'b1111, a, ~pins_out.data};
  endtask : rd
  // Common memory probe; result taken before any clock edge
  task automatic cs(input logic [25:0] a, input logic s, output logic c);
    go(1);
    pins_out = {2'b10, ~s, 1'b1, a, ~pins_out.data};
    #1;
    c = cs_n_in;
    go(1);
    pins_out = {4'b1111, a, ~pins_out.data};
  endtask : cs
endmodule : hcr_host_model
`default_nettype wire

// *** hcr_pkg.sv ***
// Package for the host configuration register bank.
// Assumes attribute-memory byte addresses on a 26-bit pin address bus.
package hcr_pkg;

  // Register byte addresses in attribute memory
  localparam logic [25:0] HCR_BUS_CTRL_ADDR = 26'h2000040;
  localparam logic [25:0] HCR_CLK_CTRL_ADDR = 26'h2000042;
  localparam logic [25:0] HCR_IF_SETUP_ADDR = 26'h2000044;
  localparam logic [25:0] HCR_ISA_ACT_ADDR = 26'h2000046;
  localparam logic [25:0] HCR_WIN_BASE_L_ADDR = 26'h2000080;
  localparam logic [25:0] HCR_WIN_BASE_H_ADDR = 26'h2000082;
  localparam logic [25:0] HCR_WIN_CTRL_ADDR = 26'h2000084;
  localparam logic [25:0] HCR_WIN_RANGE_L_ADDR = 26'h2000086;
  localparam logic [25:0] HCR_WIN_RANGE_H_ADDR = 26'h2000088;

  // Field positions
  localparam int HCR_UCODE_BIT = 7;
  localparam int HCR_DRIVE_LSB = 4;
  localparam int HCR_DIV0_BIT = 3;
  localparam int HCR_DIV1_BIT = 2;
  localparam int HCR_STOP_BIT = 1;
  localparam int HCR_LOW_POWER_ENABLE_BIT = 0;
  localparam int HCR_ACT_BIT = 0;
  localparam int HCR_DSIZE_BIT = 1;
  localparam int HCR_BASE_L_LSB = 4;
  localparam int HCR_RANGE_EN_BIT = 4;
  localparam int HCR_CS_A_MSB = 23;
  localparam int HCR_CS_A_LSB = 8;
  localparam int HCR_SPACE_BIT = 25;

  // Reset and fixed values
  localparam logic [7:0] HCR_BUS_CTRL_FIXED = 8'h03;
  localparam logic [7:0] HCR_IF_SETUP_RST = 8'hE0;
  localparam logic [7:0] HCR_ZERO_BYTE = 8'h00;
  localparam logic [3:0] HCR_ZERO_NIB = 4'h0;

  // Synchroniser depth for pin inputs
  localparam int HCR_SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    HCR_DRIVE_FULL,
    HCR_DRIVE_TWO_THIRDS,
    HCR_DRIVE_ONE_THIRD,
    HCR_DRIVE_OFF
  } hcr_drive_t;

  typedef enum logic [1:0] {
    HCR_DIV_ONE,
    HCR_DIV_THREE_QUARTER,
    HCR_DIV_HALF,
    HCR_DIV_OFF
  } hcr_divide_t;

  typedef struct packed {
    logic reg_n;
    logic ce1_n;
    logic oe_n;
    logic we_n;
    logic [25:0] addr;
    logic [7:0] data;
  } hcr_pins_t;

  typedef struct packed {
    logic oscillator_stop;
    logic low_power_enable;
    hcr_divide_t divide;
    hcr_drive_t drive;
  } hcr_clock_ctrl_t;

endpackage : hcr_pkg

// *** hcr_regs.sv ***
// Host configuration register bank reached through attribute memory pins.
// Assumes pins are asynchronous to clock_in and that a host strobe is held
// for several clock_in periods; chip-select base and mask come from elsewhere.
//
// Function
// - Microcode enable bit lets RISC run RAM code
// - Drive field sets clock output strength or off
// - Divide field picks clock output rate or off
// - Stop bit halts oscillator during power-down
// - Low-power bit gates internal clocks in power-down
// - Clock control: config state only, resets zero
// - Interface setup read-only, fixed reset value
// - Chip select decoded combinationally from raw pins
// - Activate bit enables ISA responses; rest zero
// - Activate register reachable in config state only
// - Window base: writable 23..12, low zero
// - Data size bit selects 16/8-bit; rest zero
// - Range bits read as length, low nibble zero
// - Only range bit 12 writable, acts enable
// - Enabled window reads back 4 kbyte range in config state
// - Disabled window reads back zero range
// - Power-down request enters chosen low-power mode
`timescale 1ns/1ps
`default_nettype none
module hcr_regs
  import hcr_pkg::*;
#(
  parameter int ADDR_W = 26
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic pc_reg_n_in,
  input wire logic pc_ce1_n_in,
  input wire logic pc_oe_n_in,
  input wire logic pc_we_n_in,
  input wire logic [ADDR_W-1:0] pc_addr_in,
  input wire logic [7:0] pc_data_in,
  output logic [7:0] pc_data_out,
  output logic pc_data_oe_out,
  input wire logic config_state_in,
  input wire logic power_down_request_in,
  input wire logic [15:0] chipsel_base_address_in,
  input wire logic [15:0] chipsel_range_in,
  output logic external_chip_select_n_out,
  output logic ram_microcode_enable_out,
  output logic clock_output_pin_out,
  output logic clock_output_enable_out,
  output logic [1:0] clock_out_drive_out,
  output logic oscillator_stop_out,
  output logic internal_clock_gate_out,
  output logic internal_data_width_out,
  output logic chipsel_data_width_out,
  output logic [3:0] chipsel_range_code_out,
  output logic isa_activate_bit_out,
  output logic [23:0] window_base_out,
  output logic window_data_size_out,
  output logic window_enable_out
);

  if (ADDR_W != 26) begin : g_addr_check
    $error("hcr_regs needs a 26-bit attribute address");
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  hcr_pins_t pins_raw;
  hcr_pins_t sync_reg [HCR_SYNC_STAGES];
  hcr_pins_t pins;
  logic we_low_stable;
  logic oe_low_stable;
  logic we_low_prev_reg;
  logic sel;
  logic write_pulse;
  logic [7:0] wdata;

  logic ucode_reg;
  hcr_clock_ctrl_t clk_ctrl_reg;
  logic [7:0] if_setup_reg;
  logic act_reg;
  logic [7:0] base_h_reg;
  logic [3:0] base_l_reg;
  logic dsize_reg;
  logic range_en_reg;
  logic [7:0] read_next;
  logic [7:0] range_l_view;
  logic [7:0] range_h_view;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; only the last two stages are ever compared
  assign pins_raw = '{reg_n: pc_reg_n_in, ce1_n: pc_ce1_n_in, oe_n: pc_oe_n_in,
                      we_n: pc_we_n_in, addr: pc_addr_in, data: pc_data_in};

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < HCR_SYNC_STAGES; i++) begin
        sync_reg[i] <= '{reg_n: 1'b1, ce1_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      end
    end else begin
      sync_reg[0] <= pins_raw;
      for (int i = 1; i < HCR_SYNC_STAGES; i++) begin
        sync_reg[i] <= sync_reg[i-1];
      end
    end
  end

  assign pins = sync_reg[HCR_SYNC_STAGES-1];
  assign we_low_stable = !sync_reg[1].we_n && !sync_reg[2].we_n;
  assign oe_low_stable = !sync_reg[1].oe_n && !sync_reg[2].oe_n;
  assign sel = !pins.reg_n && !pins.ce1_n && pins.addr[HCR_SPACE_BIT];

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      we_low_prev_reg <= 1'b0;
    end else begin
      we_low_prev_reg <= we_low_stable;
    end
  end

  // One write per strobe, taken when the low level is confirmed
  assign write_pulse = we_low_stable && !we_low_prev_reg && sel;
  assign wdata = pins.data;

  function automatic logic hit(input logic [25:0] a, input logic [25:0] target);
    hit = (a == target);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ucode_reg <= 1'b0;
    end else if (write_pulse && hit(pins.addr, HCR_BUS_CTRL_ADDR)) begin
      ucode_reg <= wdata[HCR_UCODE_BIT];
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_ctrl_reg <= '{oscillator_stop: 1'b0, low_power_enable: 1'b0,
                        divide: HCR_DIV_ONE, drive: HCR_DRIVE_FULL};
    end else if (write_pulse && config_state_in && hit(pins.addr, HCR_CLK_CTRL_ADDR)) begin
      clk_ctrl_reg.drive <= hcr_drive_t'(wdata[HCR_DRIVE_LSB +: 2]);
      clk_ctrl_reg.divide <= hcr_divide_t'({wdata[HCR_DIV1_BIT], wdata[HCR_DIV0_BIT]});
      clk_ctrl_reg.oscillator_stop <= wdata[HCR_STOP_BIT];
      clk_ctrl_reg.low_power_enable <= wdata[HCR_LOW_POWER_ENABLE_BIT];
    end
  end

  // Loaded at reset and never written, so a stray host write cannot remap
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      if_setup_reg <= HCR_IF_SETUP_RST;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      act_reg <= 1'b0;
    end else if (write_pulse && config_state_in && hit(pins.addr, HCR_ISA_ACT_ADDR)) begin
      act_reg <= wdata[HCR_ACT_BIT];
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      base_h_reg <= HCR_ZERO_BYTE;
      base_l_reg <= HCR_ZERO_NIB;
    end else if (write_pulse && hit(pins.addr, HCR_WIN_BASE_H_ADDR)) begin
      base_h_reg <= wdata;
    end else if (write_pulse && hit(pins.addr, HCR_WIN_BASE_L_ADDR)) begin
      base_l_reg <= wdata[HCR_BASE_L_LSB +: 4];
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dsize_reg <= 1'b0;
    end else if (write_pulse && hit(pins.addr, HCR_WIN_CTRL_ADDR)) begin
      dsize_reg <= wdata[HCR_DSIZE_BIT];
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      range_en_reg <= 1'b0;
    end else if (write_pulse && config_state_in && hit(pins.addr, HCR_WIN_RANGE_L_ADDR)) begin
      range_en_reg <= wdata[HCR_RANGE_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; range reads as a 4 kbyte length mask or zero
  assign range_l_view = {{4{range_en_reg}}, HCR_ZERO_NIB};
  assign range_h_view = {8{range_en_reg}};

  always_comb begin
    read_next = HCR_ZERO_BYTE;
    if (hit(pins.addr, HCR_BUS_CTRL_ADDR)) begin
      read_next = HCR_BUS_CTRL_FIXED;
      read_next[HCR_UCODE_BIT] = ucode_reg;
    end else if (hit(pins.addr, HCR_CLK_CTRL_ADDR) && config_state_in) begin
      read_next[HCR_DRIVE_LSB +: 2] = clk_ctrl_reg.drive;
      read_next[HCR_DIV1_BIT] = clk_ctrl_reg.divide[1];
      read_next[HCR_DIV0_BIT] = clk_ctrl_reg.divide[0];
      read_next[HCR_STOP_BIT] = clk_ctrl_reg.oscillator_stop;
      read_next[HCR_LOW_POWER_ENABLE_BIT] = clk_ctrl_reg.low_power_enable;
    end else if (hit(pins.addr, HCR_IF_SETUP_ADDR)) begin
      read_next = if_setup_reg;
    end else if (hit(pins.addr, HCR_ISA_ACT_ADDR) && config_state_in) begin
      read_next[HCR_ACT_BIT] = act_reg;
    end else if (hit(pins.addr, HCR_WIN_BASE_H_ADDR)) begin
      read_next = base_h_reg;
    end else if (hit(pins.addr, HCR_WIN_BASE_L_ADDR)) begin
      read_next = {base_l_reg, HCR_ZERO_NIB};
    end else if (hit(pins.addr, HCR_WIN_CTRL_ADDR)) begin
      read_next[HCR_DSIZE_BIT] = dsize_reg;
    end else if (hit(pins.addr, HCR_WIN_RANGE_L_ADDR) && config_state_in) begin
      read_next = range_l_view;
    end else if (hit(pins.addr, HCR_WIN_RANGE_H_ADDR) && config_state_in) begin
      read_next = range_h_view;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_data_out <= HCR_ZERO_BYTE;
    end else begin
      pc_data_out <= read_next;
    end
  end

  // Bus driven only while a register read is confirmed on the pins
  assign pc_data_oe_out = oe_low_stable && sel;

  ////////////////////////////////////////////////////////////////////////////
  // External chip select: raw pins, no clock, so it follows the strobes
  always_comb begin
    external_chip_select_n_out = !(pc_reg_n_in && pc_addr_in[HCR_SPACE_BIT]
      && (((pc_addr_in[HCR_CS_A_MSB:HCR_CS_A_LSB] ^ chipsel_base_address_in)
           & chipsel_range_in) == 16'h0000)
      && (!pc_oe_n_in || !pc_we_n_in));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs
  assign ram_microcode_enable_out = ucode_reg;
  assign clock_out_drive_out = clk_ctrl_reg.drive;
  assign oscillator_stop_out = power_down_request_in && clk_ctrl_reg.oscillator_stop;
  assign internal_clock_gate_out = power_down_request_in && clk_ctrl_reg.low_power_enable;
  assign internal_data_width_out = if_setup_reg[5];
  assign chipsel_data_width_out = if_setup_reg[4];
  assign chipsel_range_code_out = if_setup_reg[3:0];
  assign isa_activate_bit_out = act_reg;
  assign window_base_out = {base_h_reg, base_l_reg, 12'h000};
  assign window_data_size_out = dsize_reg;
  assign window_enable_out = range_en_reg;

  hcr_clock_out u_clock_out (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .divide_in(clk_ctrl_reg.divide),
    .drive_in(clk_ctrl_reg.drive),
    .stopped_in(oscillator_stop_out),
    .clock_out(clock_output_pin_out),
    .enable_out(clock_output_enable_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_ucode_write: assert property (write_pulse && hit(pins.addr, HCR_BUS_CTRL_ADDR)
    |=> ram_microcode_enable_out == $past(wdata[HCR_UCODE_BIT]))
    else $error("microcode enable did not follow write");
  a_clkctl_locked: assert property (!config_state_in |=> $stable(clk_ctrl_reg))
    else $error("clock control changed outside config state");
  a_isi_fixed: assert property (hit(pins.addr, HCR_IF_SETUP_ADDR)
    |=> pc_data_out == HCR_IF_SETUP_RST && if_setup_reg == HCR_IF_SETUP_RST)
    else $error("interface setup value changed");
  a_chipsel_idle: assert property ((pc_oe_n_in && pc_we_n_in) |-> external_chip_select_n_out)
    else $error("chip select active without strobe");
  a_act_locked: assert property (!config_state_in |=> $stable(act_reg))
    else $error("activate bit changed outside config state");
  a_act_reserved: assert property (hit(pins.addr, HCR_ISA_ACT_ADDR) |=> pc_data_out[7:1] == 7'h00)
    else $error("activate reserved bits not zero");
  a_base_low_zero: assert property (write_pulse && hit(pins.addr, HCR_WIN_BASE_L_ADDR)
    |=> window_base_out[15:12] == $past(wdata[HCR_BASE_L_LSB +: 4]) && window_base_out[11:0] == 12'h000)
    else $error("window base low bits wrong");
  a_ctrl_reserved: assert property (hit(pins.addr, HCR_WIN_CTRL_ADDR) |=> pc_data_out[7:2] == 6'h00)
    else $error("window control reserved bits not zero");
  a_range_read: assert property (config_state_in && hit(pins.addr, HCR_WIN_RANGE_H_ADDR)
    |=> pc_data_out == ($past(range_en_reg) ? 8'hFF : 8'h00))
    else $error("range high readback wrong");
  a_range_low_read: assert property (config_state_in && hit(pins.addr, HCR_WIN_RANGE_L_ADDR)
    |=> pc_data_out == ($past(range_en_reg) ? 8'hF0 : 8'h00))
    else $error("range low readback wrong");
  a_clkctl_write: assert property (write_pulse && config_state_in && hit(pins.addr, HCR_CLK_CTRL_ADDR)
    |=> clock_out_drive_out == $past(wdata[HCR_DRIVE_LSB +: 2])
    && clk_ctrl_reg.divide == $past({wdata[HCR_DIV1_BIT], wdata[HCR_DIV0_BIT]}))
    else $error("clock control did not follow write");
  a_powerdown_stop: assert property (power_down_request_in && clk_ctrl_reg.oscillator_stop
    |-> oscillator_stop_out ##1 clock_output_pin_out)
    else $error("oscillator stop not applied");
  a_lowpower_gate: assert property (!power_down_request_in |-> !internal_clock_gate_out)
    else $error("clocks gated without power-down");

endmodule : hcr_regs
`default_nettype wire

// *** test_host_config_registers.sv ***
// Self-checking bench for the host configuration register bank.
// Assumes hcr_pkg, hcr_regs and hcr_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module test_host_config_registers;
  import hcr_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cfg = 1'b1;
  logic pd = 1'b0;
  logic [15:0] cs_base = 16'h0000;
  logic [15:0] cs_mask = 16'h0000;
  hcr_pins_t pins;
  logic oe, cs_n, clk_pin, clk_en, uc, ostop, cgate, idw, cdw, act, dsz, wen, p, off, s;
  logic [1:0] drv;
  logic [3:0] crc, m_bl;
  logic [23:0] wbase;
  logic [7:0] rdata, v, m_clk = 8'h00, m_bh = 8'h00;
  logic m_uc = 1'b0, m_act = 1'b0, m_ds = 1'b0, m_en = 1'b0;
  logic [25:0] a;
  int err_total = 0;
  int samples_checked = 0;
  int seed = 95342;
  int n;
  logic [25:0] al [10] = '{HCR_BUS_CTRL_ADDR, HCR_CLK_CTRL_ADDR, HCR_IF_SETUP_ADDR, HCR_ISA_ACT_ADDR,
    HCR_WIN_BASE_L_ADDR, HCR_WIN_BASE_H_ADDR, HCR_WIN_CTRL_ADDR, HCR_WIN_RANGE_L_ADDR,
    HCR_WIN_RANGE_H_ADDR, 26'h20000FE};
  initial forever #2 clock_in = ~clock_in;
  hcr_host_model u_host (.clock_in(clock_in), .data_in(rdata), .oe_in(oe), .cs_n_in(cs_n), .pins_out(pins));
  hcr_regs u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .pc_reg_n_in(pins.reg_n),
    .pc_ce1_n_in(pins.ce1_n), .pc_oe_n_in(pins.oe_n), .pc_we_n_in(pins.we_n), .pc_addr_in(pins.addr),
    .pc_data_in(pins.data), .pc_data_out(rdata), .pc_data_oe_out(oe), .config_state_in(cfg),
    .power_down_request_in(pd), .chipsel_base_address_in(cs_base), .chipsel_range_in(cs_mask),
    .external_chip_select_n_out(cs_n), .ram_microcode_enable_out(uc), .clock_output_pin_out(clk_pin),
    .clock_output_enable_out(clk_en), .clock_out_drive_out(drv), .oscillator_stop_out(ostop),
    .internal_clock_gate_out(cgate), .internal_data_width_out(idw), .chipsel_data_width_out(cdw),
    .chipsel_range_code_out(crc), .isa_activate_bit_out(act), .window_base_out(wbase),
    .window_data_size_out(dsz), .window_enable_out(wen));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] mdl_rd(input logic [25:0] ad);
    case (ad)
      HCR_BUS_CTRL_ADDR: return {m_uc, 7'h03};
      HCR_CLK_CTRL_ADDR: return cfg ? m_clk : 8'h00;
      HCR_IF_SETUP_ADDR: return 8'hE0;
      HCR_ISA_ACT_ADDR: return {7'h00, cfg & m_act};
      HCR_WIN_BASE_L_ADDR: return {m_bl, 4'h0};
      HCR_WIN_BASE_H_ADDR: return m_bh;
      HCR_WIN_CTRL_ADDR: return {6'h00, m_ds, 1'b0};
      HCR_WIN_RANGE_L_ADDR: return {{4{cfg & m_en}}, 4'h0};
      HCR_WIN_RANGE_H_ADDR: return {8{cfg & m_en}};
      default: return 8'h00;
    endcase
  endfunction : mdl_rd
  task automatic w(input logic [25:0] ad, input logic [7:0] d);
    u_host.wr(ad, d);
    if (ad == HCR_BUS_CTRL_ADDR) m_uc = d[7];
    if (ad == HCR_CLK_CTRL_ADDR && cfg) m_clk = d & 8'h3F;
    if (ad == HCR_ISA_ACT_ADDR && cfg) m_act = d[0];
    if (ad == HCR_WIN_BASE_H_ADDR) m_bh = d;
    if (ad == HCR_WIN_BASE_L_ADDR) m_bl = d[7:4];
    if (ad == HCR_WIN_CTRL_ADDR) m_ds = d[1];
    if (ad == HCR_WIN_RANGE_L_ADDR && cfg) m_en = d[4];
    `CHK("ucode", m_uc, uc)
    `CHK("drive", m_clk[5:4], drv)
    `CHK("osc_stop", m_clk[1] & pd, ostop)
    `CHK("clk_gate", m_clk[0] & pd, cgate)
    `CHK("isa_act", m_act, act)
    `CHK("win_base", {m_bh, m_bl, 12'h000}, wbase)
    `CHK("win_size", m_ds, dsz)
    `CHK("win_en", m_en, wen)
  endtask : w
  task automatic r(input logic [25:0] ad);
    u_host.rd(ad, v, s);
    `CHK("data_oe", 1'b1, s)
    `CHK("rd_data", mdl_rd(ad), v)
  endtask : r
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(negedge clock_in);
    rst_n_in = 1'b1;
    foreach (al[i]) r(al[i]);
    `CHK("int_width", 1'b1, idw)
    `CHK("cs_width", 1'b0, cdw)
    `CHK("cs_code", 4'h0, crc)
    $display("test reset done");
    w(HCR_BUS_CTRL_ADDR, 8'h80);
    r(HCR_BUS_CTRL_ADDR);
    w(HCR_IF_SETUP_ADDR, 8'h1F);
    r(HCR_IF_SETUP_ADDR);
    $display("test ucode setup done");
    for (int i = 0; i < 16; i++) begin
      w(HCR_CLK_CTRL_ADDR, {2'b00, i[3:2], i[0], i[1], 2'b00});
      r(HCR_CLK_CTRL_ADDR);
      off = (i[3:2] == 3 || i[1:0] == 3);
      p = clk_pin;
      n = 0;
      repeat (16) begin
        @(negedge clock_in);
        n += (clk_pin !== p);
        p = clk_pin;
      end
      `CHK("toggles", off ? 0 : 16 - 4 * i[1:0], n)
      `CHK("clk_en", !off, clk_en)
      if (off) `CHK("pin_high", 1'b1, clk_pin)
    end
    $display("test clock out done");
    for (int i = 0; i < 8; i++) begin
      pd = i[0];
      w(HCR_CLK_CTRL_ADDR, {6'h00, i[2:1]});
      `CHK("osc_en", !(i[2] & i[0]), clk_en)
    end
    pd = 1'b0;
    $display("test power down done");
    cfg = 1'b0;
    w(HCR_CLK_CTRL_ADDR, 8'h3F);
    w(HCR_ISA_ACT_ADDR, 8'hFF);
    w(HCR_WIN_RANGE_L_ADDR, 8'hFF);
    foreach (al[i]) r(al[i]);
    cfg = 1'b1;
    foreach (al[i]) r(al[i]);
    w(HCR_ISA_ACT_ADDR, 8'hFF);
    r(HCR_ISA_ACT_ADDR);
    $display("test config state done");
    v = $random(seed);
    w(HCR_WIN_BASE_H_ADDR, v);
    v = $random(seed);
    w(HCR_WIN_BASE_L_ADDR, v & 8'hF0);
    w(HCR_WIN_CTRL_ADDR, 8'hFF);
    w(HCR_WIN_RANGE_L_ADDR, 8'hFF);
    w(HCR_WIN_RANGE_H_ADDR, 8'h00);
    foreach (al[i]) r(al[i]);
    w(HCR_WIN_RANGE_L_ADDR, 8'hEF);
    w(HCR_WIN_CTRL_ADDR, 8'h00);
    foreach (al[i]) r(al[i]);
    $display("test window done");
    for (int i = 0; i < 24; i++) begin
      @(negedge clock_in);
      cs_base = $random(seed);
      cs_mask = $random(seed);
      a = $random(seed);
      if (i[0]) a[23:8] = cs_base ^ (16'($random(seed)) & ~cs_mask);
      a[25] = (i % 6 != 5);
      s = (i % 4 != 3);
      u_host.cs(a, s, p);
      `CHK("chip_sel_n", !(a[25] & s & (((a[23:8] ^ cs_base) & cs_mask) == 16'h0000)), p)
    end
    $display("test chip select done");
    report_and_stop();
  end
endmodule : test_host_config_registers
`default_nettype wire
